// ### include/bsu_consts.svh
// timing constants for the single-operand, shift and bit-field timing unit
// Operation
// - each operand bus cycle takes two clocks
// - totals include every read, prefetch, write cycle
// - uncached figure adds one clock, for unary memory forms only
// - address phase runs before memory operation time
// - unary ops: register 2, memory 3/4
// - extend 4, set-cond 4, decimal 6, tas 12
// - shift time ignores count except logical and arithmetic right register count
// - logical register-count shift: 6, over size 8
// - arithmetic right register-count shift: 6 or 10
// - left and right logical shifts and rotates take equal time
// - asl 6/8, rotate-extend 12, memory shifts 4/6
// - bit test 4 no write, modify 6
// - field register clocks 8,10,12,14,20; one read
// - five-byte field needs two operand cycles each
// - field memory totals exclude separate address time
`ifndef BSU_CONSTS_SVH
`define BSU_CONSTS_SVH
`define BSU_TOT_W      6
`define BSU_EA_W       8
`define BSU_BUS_CLKS   6'h02
`define BSU_ONE_CYC    2'h1
`define BSU_TWO_CYC    2'h2
`define BSU_UNARY_REG  6'h02
`define BSU_UNARY_MEM  6'h03
`define BSU_NC_EXTRA   6'h01
`define BSU_SEXT_REG   6'h04
`define BSU_DNEG_REG   6'h06
`define BSU_SCC_REG    6'h04
`define BSU_SCC_MEM    6'h05
`define BSU_TAS_REG    6'h04
`define BSU_TAS_MEM    6'h0C
`define BSU_TST_CLKS   6'h02
`define BSU_LSH_IMM    6'h04
`define BSU_LSH_IN     6'h06
`define BSU_LSH_OVER   6'h08
`define BSU_LSH_MEM    6'h04
`define BSU_ASL_IMM    6'h06
`define BSU_ASL_REG    6'h08
`define BSU_ASL_MEM    6'h06
`define BSU_ASR_IMM    6'h04
`define BSU_ASR_IN     6'h06
`define BSU_ASR_OVER   6'h0A
`define BSU_ASR_MEM    6'h04
`define BSU_ROT_IMM    6'h06
`define BSU_ROT_REG    6'h08
`define BSU_ROT_MEM    6'h06
`define BSU_ROX_REG    6'h0C
`define BSU_ROX_MEM    6'h04
`define BSU_SINGLE_BIT_TEST_CLKS  6'h04
`define BSU_BMOD_CLKS  6'h06
`define BSU_FTST_REG   6'h08
`define BSU_FTST_M4    6'h0A
`define BSU_FTST_M5    6'h0E
`define BSU_FMOD_REG   6'h0E
`define BSU_FMOD_M4    6'h0E
`define BSU_FMOD_M5    6'h16
`define BSU_FEXT_REG   6'h0A
`define BSU_FEXT_M4    6'h0C
`define BSU_FEXT_M5    6'h12
`define BSU_FINS_REG   6'h0C
`define BSU_FINS_M4    6'h0C
`define BSU_FINS_M5    6'h12
`define BSU_FFFO_REG   6'h14
`define BSU_FFFO_M4    6'h16
`define BSU_FFFO_M5    6'h1C
`endif

// ### include/bsu_pkg.sv
// types shared by the timing unit
package bsu_pkg;
  typedef enum logic [4:0] {
    OP_CLEAR_OPERAND, OP_NEGATE_OPERAND, OP_NEGATE_WITH_EXTEND,
    OP_ONES_COMPLEMENT, OP_SIGN_EXTEND, OP_DECIMAL_NEGATE, OP_SET_ON_COND,
    OP_TEST_AND_SET, OP_TEST_OPERAND,
    OP_LOGICAL_SHIFT_IMM, OP_LOGICAL_SHIFT_REG,
    OP_ARITH_SHIFT_LEFT_IMM, OP_ARITH_SHIFT_LEFT_REG,
    OP_ARITH_SHIFT_RIGHT_IMM, OP_ARITH_SHIFT_RIGHT_REG,
    OP_ROTATE_PLAIN_IMM, OP_ROTATE_PLAIN_REG, OP_ROTATE_THROUGH_EXTEND,
    OP_SINGLE_BIT_TEST, OP_SINGLE_BIT_CHANGE, OP_SINGLE_BIT_CLEAR,
    OP_SINGLE_BIT_SET, OP_FIELD_TEST, OP_FIELD_CHANGE, OP_FIELD_CLEAR,
    OP_FIELD_SET, OP_FIELD_EXTRACT_SIGNED, OP_FIELD_EXTRACT_UNSIGNED,
    OP_FIELD_INSERT, OP_FIELD_FIND_FIRST_ONE
  } bsu_op_e;

  typedef enum {ST_IDLE, ST_ADDR, ST_EXEC} bsu_state_e;

  typedef struct packed {
    logic [5:0] tot;
    logic [1:0] rd;
    logic [1:0] pf;
    logic [1:0] wr;
  } bsu_tim_s;
endpackage

// ### hw/bsu_exec.sv
// execution timing sequencer for unary, shift and bit operations
`timescale 1ns/1ps
`include "bsu_consts.svh"
module bsu_exec (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // issue from decode
  input  wire logic                    issue_valid,
  output logic                         issue_ready,
  input  bsu_pkg::bsu_op_e             issue_op,
  input  wire logic                    issue_mem,
  input  wire logic                    issue_cached,
  input  wire logic                    issue_span5,
  input  wire logic                    issue_count_over,
  input  wire logic [`BSU_EA_W-1:0]    issue_ea_clks,
  // bus controller
  input  wire logic                    bus_wait,
  output logic                         bus_read,
  output logic                         bus_prefetch,
  output logic                         bus_write,
  // status
  output logic                         busy,
  output logic                         done,
  output logic [`BSU_TOT_W-1:0]        cycle_total
);
  // clocks spent in n two-clock bus cycles
  function automatic logic [5:0] bus_span(input logic [1:0] n);
    return {4'h0, n} * `BSU_BUS_CLKS;
  endfunction

  // listed figure for one operation form
  function automatic bsu_pkg::bsu_tim_s op_timing(
    input bsu_pkg::bsu_op_e op, input logic mem, input logic cached,
    input logic span5, input logic over);
    bsu_pkg::bsu_tim_s t;
    logic [1:0] frd;
    logic       unary;
    t = '0;
    frd = span5 ? `BSU_TWO_CYC : `BSU_ONE_CYC;
    unary = 1'b0;
    unique case (op)
      bsu_pkg::OP_CLEAR_OPERAND, bsu_pkg::OP_NEGATE_OPERAND,
      bsu_pkg::OP_NEGATE_WITH_EXTEND, bsu_pkg::OP_ONES_COMPLEMENT: begin
        t.tot = mem ? `BSU_UNARY_MEM : `BSU_UNARY_REG;
        t.wr  = mem ? `BSU_ONE_CYC : 2'h0;
        unary = mem;
      end
      bsu_pkg::OP_SIGN_EXTEND: t.tot = `BSU_SEXT_REG;
      bsu_pkg::OP_DECIMAL_NEGATE: t.tot = `BSU_DNEG_REG;
      bsu_pkg::OP_SET_ON_COND: begin
        t.tot = mem ? `BSU_SCC_MEM : `BSU_SCC_REG;
        t.wr  = mem ? `BSU_ONE_CYC : 2'h0;
      end
      bsu_pkg::OP_TEST_AND_SET: begin
        t.tot = mem ? `BSU_TAS_MEM : `BSU_TAS_REG;
        t.rd  = mem ? `BSU_ONE_CYC : 2'h0;
        t.wr  = mem ? `BSU_ONE_CYC : 2'h0;
      end
      bsu_pkg::OP_TEST_OPERAND: t.tot = `BSU_TST_CLKS;
      // direction is not an input: left and right share one figure
      bsu_pkg::OP_LOGICAL_SHIFT_IMM:
        t.tot = mem ? `BSU_LSH_MEM : `BSU_LSH_IMM;
      bsu_pkg::OP_LOGICAL_SHIFT_REG:
        t.tot = over ? `BSU_LSH_OVER : `BSU_LSH_IN;
      bsu_pkg::OP_ARITH_SHIFT_LEFT_IMM:
        t.tot = mem ? `BSU_ASL_MEM : `BSU_ASL_IMM;
      bsu_pkg::OP_ARITH_SHIFT_LEFT_REG: t.tot = `BSU_ASL_REG;
      bsu_pkg::OP_ARITH_SHIFT_RIGHT_IMM:
        t.tot = mem ? `BSU_ASR_MEM : `BSU_ASR_IMM;
      bsu_pkg::OP_ARITH_SHIFT_RIGHT_REG:
        t.tot = over ? `BSU_ASR_OVER : `BSU_ASR_IN;
      bsu_pkg::OP_ROTATE_PLAIN_IMM:
        t.tot = mem ? `BSU_ROT_MEM : `BSU_ROT_IMM;
      bsu_pkg::OP_ROTATE_PLAIN_REG: t.tot = `BSU_ROT_REG;
      bsu_pkg::OP_ROTATE_THROUGH_EXTEND:
        t.tot = mem ? `BSU_ROX_MEM : `BSU_ROX_REG;
      bsu_pkg::OP_SINGLE_BIT_TEST: t.tot = `BSU_SINGLE_BIT_TEST_CLKS;
      bsu_pkg::OP_SINGLE_BIT_CHANGE, bsu_pkg::OP_SINGLE_BIT_CLEAR,
      bsu_pkg::OP_SINGLE_BIT_SET: begin
        t.tot = `BSU_BMOD_CLKS;
        t.wr  = mem ? `BSU_ONE_CYC : 2'h0;
      end
      bsu_pkg::OP_FIELD_TEST: begin
        t.tot = !mem ? `BSU_FTST_REG : span5 ? `BSU_FTST_M5 : `BSU_FTST_M4;
        t.rd  = mem ? frd : 2'h0;
      end
      bsu_pkg::OP_FIELD_CHANGE, bsu_pkg::OP_FIELD_CLEAR,
      bsu_pkg::OP_FIELD_SET: begin
        t.tot = !mem ? `BSU_FMOD_REG : span5 ? `BSU_FMOD_M5 : `BSU_FMOD_M4;
        t.rd  = mem ? frd : 2'h0;
        t.wr  = mem ? frd : 2'h0;
      end
      bsu_pkg::OP_FIELD_EXTRACT_SIGNED, bsu_pkg::OP_FIELD_EXTRACT_UNSIGNED:
      begin
        t.tot = !mem ? `BSU_FEXT_REG : span5 ? `BSU_FEXT_M5 : `BSU_FEXT_M4;
        t.rd  = mem ? frd : 2'h0;
      end
      bsu_pkg::OP_FIELD_INSERT: begin
        t.tot = !mem ? `BSU_FINS_REG : span5 ? `BSU_FINS_M5 : `BSU_FINS_M4;
        t.rd  = mem ? frd : 2'h0;
        t.wr  = mem ? frd : 2'h0;
      end
      bsu_pkg::OP_FIELD_FIND_FIRST_ONE: begin
        t.tot = !mem ? `BSU_FFFO_REG : span5 ? `BSU_FFFO_M5 : `BSU_FFFO_M4;
        t.rd  = mem ? frd : 2'h0;
      end
      default: t.tot = `BSU_UNARY_REG; // unused encodings run as a nop
    endcase
    // a memory shift other than rotate-through-extend moves one bit and writes the operand back
    if (mem && (op inside {bsu_pkg::OP_LOGICAL_SHIFT_IMM,
        bsu_pkg::OP_ARITH_SHIFT_LEFT_IMM, bsu_pkg::OP_ARITH_SHIFT_RIGHT_IMM,
        bsu_pkg::OP_ROTATE_PLAIN_IMM})) t.wr = `BSU_ONE_CYC;
    // uncached stream fetches one word inside the listed total
    if (!cached) begin
      t.pf = `BSU_ONE_CYC;
      if (unary) t.tot = t.tot + `BSU_NC_EXTRA;
    end
    return t;
  endfunction

  bsu_pkg::bsu_state_e state_q, state_d;
  bsu_pkg::bsu_tim_s   tim_q, tim_d;
  logic [5:0]          pos_q, pos_d;
  logic [`BSU_EA_W-1:0] ea_q, ea_d;
  logic                accept, in_rd, in_pf, in_wr, hold, last;
  logic [5:0]          rd_end, pf_end, wr_beg;

  // bus windows: reads first, then prefetch, writes close the operation
  always_comb begin
    rd_end = bus_span(tim_q.rd);
    pf_end = rd_end + bus_span(tim_q.pf);
    wr_beg = tim_q.tot - bus_span(tim_q.wr);
    in_rd  = (state_q == bsu_pkg::ST_EXEC) && (pos_q < rd_end);
    in_pf  = (state_q == bsu_pkg::ST_EXEC) && !in_rd && (pos_q < pf_end);
    in_wr  = (state_q == bsu_pkg::ST_EXEC) && (pos_q >= wr_beg);
    // a slow bus stretches the operation rather than losing a cycle
    hold   = (in_rd || in_pf || in_wr) && bus_wait;
    last   = (state_q == bsu_pkg::ST_EXEC) && !hold &&
             (pos_q == tim_q.tot - 6'h01);
  end
  assign busy         = (state_q != bsu_pkg::ST_IDLE);
  assign issue_ready  = !busy;
  assign accept       = issue_valid && issue_ready;
  assign bus_read     = in_rd;
  assign bus_prefetch = in_pf;
  assign bus_write    = in_wr;
  assign done         = last;
  assign cycle_total  = tim_q.tot;
  // sequencer next state
  always_comb begin
    state_d = state_q;
    tim_d   = tim_q;
    pos_d   = pos_q;
    ea_d    = ea_q;
    unique case (state_q)
      bsu_pkg::ST_IDLE: begin
        if (accept) begin
          tim_d = op_timing(issue_op, issue_mem, issue_cached,
                            issue_span5, issue_count_over);
          pos_d = 6'h00;
          ea_d  = issue_ea_clks;
          // address work is its own phase ahead of the listed time
          state_d = (issue_mem && (issue_ea_clks != '0)) ?
                    bsu_pkg::ST_ADDR : bsu_pkg::ST_EXEC;
        end
      end
      bsu_pkg::ST_ADDR: begin
        ea_d = ea_q - 1'b1;
        if (ea_q == {{(`BSU_EA_W-1){1'b0}}, 1'b1}) begin
          state_d = bsu_pkg::ST_EXEC;
        end
      end
      bsu_pkg::ST_EXEC: begin
        if (last) begin
          state_d = bsu_pkg::ST_IDLE;
        end else if (!hold) begin
          pos_d = pos_q + 6'h01;
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= bsu_pkg::ST_IDLE;
      tim_q   <= '0;
      pos_q   <= 6'h00;
      ea_q    <= '0;
    end else begin
      state_q <= state_d;
      tim_q   <= tim_d;
      pos_q   <= pos_d;
      ea_q    <= ea_d;
    end
  end
  // helper counters seen only by the checks below
  logic [5:0] len_q, rdc_q, wrc_q;
  logic       stall_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || accept) begin
      len_q <= 6'h00;
      rdc_q <= 6'h00;
      wrc_q <= 6'h00;
      stall_q <= 1'b0;
    end else begin
      if (state_q == bsu_pkg::ST_EXEC) len_q <= len_q + 6'h01;
      if (in_rd && !bus_wait) rdc_q <= rdc_q + 6'h01;
      if (in_wr && !bus_wait) wrc_q <= wrc_q + 6'h01;
      if (hold) stall_q <= 1'b1;
    end
  end
  property p_busy_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (busy && !done) |=> busy && !issue_ready;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped during an operation");
  property p_total_len;
    @(posedge sys_clk) disable iff (!rst_n)
    (done && !stall_q) |-> (len_q + 6'h01 == tim_q.tot);
  endproperty
  a_total_len: assert property (p_total_len)
    else $error("operation length differs from listed total");
  property p_bus_counts;
    @(posedge sys_clk) disable iff (!rst_n)
    done |=> (rdc_q == bus_span($past(tim_q.rd))) &&
             (wrc_q == bus_span($past(tim_q.wr)));
  endproperty
  a_bus_counts: assert property (p_bus_counts)
    else $error("operand bus clocks do not match counts");
  property p_clr_reg;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && issue_op == bsu_pkg::OP_CLEAR_OPERAND && !issue_mem &&
     issue_cached) |=> busy [*2] ##1 !busy;
  endproperty
  a_clr_reg: assert property (p_clr_reg)
    else $error("register clear not two clocks");
  property p_clr_mem_nc;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && issue_op == bsu_pkg::OP_CLEAR_OPERAND && issue_mem &&
     !issue_cached) |=> (tim_q.tot == 6'h04) && (tim_q.pf == 2'h1);
  endproperty
  a_clr_mem_nc: assert property (p_clr_mem_nc)
    else $error("uncached memory clear not four clocks");
  property p_lsh_over;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && issue_op == bsu_pkg::OP_LOGICAL_SHIFT_REG && issue_cached &&
     issue_count_over && !issue_mem) |=> busy [*8] ##1 !busy;
  endproperty
  a_lsh_over: assert property (p_lsh_over)
    else $error("oversize logical shift not eight clocks");
  property p_asr_over;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && issue_op == bsu_pkg::OP_ARITH_SHIFT_RIGHT_REG &&
     issue_cached && issue_count_over && !issue_mem)
      |-> ##10 busy ##1 !busy;
  endproperty
  a_asr_over: assert property (p_asr_over)
    else $error("oversize arithmetic right shift not ten clocks");
  property p_tas_mem;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && issue_op == bsu_pkg::OP_TEST_AND_SET && issue_mem)
      |=> tim_q.tot == 6'h0C && tim_q.rd == 2'h1 && tim_q.wr == 2'h1;
  endproperty
  a_tas_mem: assert property (p_tas_mem)
    else $error("memory test-and-set figure wrong");
  property p_span5;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && issue_op == bsu_pkg::OP_FIELD_CHANGE && issue_mem &&
     issue_span5) |=> tim_q.rd == 2'h2 && tim_q.wr == 2'h2;
  endproperty
  a_span5: assert property (p_span5)
    else $error("five-byte field not two operand cycles");
  property p_ea_first;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && issue_mem && issue_ea_clks == 8'h03)
      |=> (state_q == bsu_pkg::ST_ADDR) [*3] ##1
          (state_q == bsu_pkg::ST_EXEC && pos_q == 6'h00);
  endproperty
  a_ea_first: assert property (p_ea_first)
    else $error("address phase length wrong");
  property p_wait_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (bus_read && bus_wait) |=> $stable(pos_q) && busy;
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("bus wait did not stretch operation");
  property p_single_bit_test_nowr;
    @(posedge sys_clk) disable iff (!rst_n)
    (accept && issue_op == bsu_pkg::OP_SINGLE_BIT_TEST)
      |=> tim_q.wr == 2'h0 && tim_q.tot == 6'h04;
  endproperty
  a_single_bit_test_nowr: assert property (p_single_bit_test_nowr)
    else $error("bit test figure wrong");
endmodule

// ### dv/bsu_mem_model.sv
// memory behind the bus controller: stretches bus windows, counts clocks
`timescale 1ns/1ps
module bsu_mem_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // bus strobes from the unit
  input  wire logic bus_read,
  input  wire logic bus_prefetch,
  input  wire logic bus_write,
  // slow memory adds one wait clock at each burst start
  input  wire logic slow,
  output logic      bus_wait,
  // clock counts seen by memory
  output int        n_rd,
  output int        n_pf,
  output int        n_wr,
  output int        n_wait
);
  logic any_q;
  logic any_b;

  // prompt memory answers each cycle in two clocks
  assign any_b    = bus_read | bus_prefetch | bus_write;
  assign bus_wait = slow & any_b & ~any_q;

  // wait clocks are not data clocks, so count them apart
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      any_q  <= 1'h0;
      n_rd   <= 0;
      n_pf   <= 0;
      n_wr   <= 0;
      n_wait <= 0;
    end else begin
      any_q  <= any_b;
      n_wait <= n_wait + int'(bus_wait);
      n_rd   <= n_rd + int'(bus_read & ~bus_wait);
      n_pf   <= n_pf + int'(bus_prefetch & ~bus_wait);
      n_wr   <= n_wr + int'(bus_write & ~bus_wait);
    end
  end
endmodule

// ### dv/tb.sv
// self-checking bench for the execution timing sequencer
`timescale 1ns/1ps
`include "bsu_consts.svh"
module tb;
  logic                  sys_clk = 1'h0;
  logic                  rst_n = 1'h0;
  logic                  issue_valid = 1'h0;
  logic                  issue_ready;
  bsu_pkg::bsu_op_e      issue_op = bsu_pkg::OP_CLEAR_OPERAND;
  logic                  issue_mem = 1'h0;
  logic                  issue_cached = 1'h1;
  logic                  issue_span5 = 1'h0;
  logic                  issue_count_over = 1'h0;
  logic [`BSU_EA_W-1:0]  issue_ea_clks = 8'h00;
  logic                  bus_wait;
  logic                  bus_read;
  logic                  bus_prefetch;
  logic                  bus_write;
  logic                  busy;
  logic                  done;
  logic [`BSU_TOT_W-1:0] cycle_total;
  logic                  slow = 1'h0;
  int                    n_rd;
  int                    n_pf;
  int                    n_wr;
  int                    n_wait;
  int                    fails = 0;
  int                    n_checks = 0;
  int                    poke = -1;
  int                    waits;

  always #5 sys_clk = ~sys_clk;

  bsu_exec uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_op(issue_op), .issue_mem(issue_mem),
    .issue_cached(issue_cached), .issue_span5(issue_span5),
    .issue_count_over(issue_count_over), .issue_ea_clks(issue_ea_clks),
    .bus_wait(bus_wait), .bus_read(bus_read),
    .bus_prefetch(bus_prefetch), .bus_write(bus_write),
    .busy(busy), .done(done), .cycle_total(cycle_total));

  bsu_mem_model mem (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus_read(bus_read), .bus_prefetch(bus_prefetch),
    .bus_write(bus_write), .slow(slow), .bus_wait(bus_wait),
    .n_rd(n_rd), .n_pf(n_pf), .n_wr(n_wr), .n_wait(n_wait));

  task automatic chk(logic [31:0] seen, logic [31:0] exp, string msg);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s seen %0h exp %0h", $time, msg, seen, exp);
    end
  endtask

  // one issue; cached ops never prefetch, uncached ones prefetch once
  task automatic run_op(int op, int m, int c, int s5, int ov, int ea,
                        int t, int r, int w);
    int k;
    int r0;
    int p0;
    int w0;
    int q0;
    r0 = n_rd;
    p0 = n_pf;
    w0 = n_wr;
    q0 = n_wait;
    issue_op = bsu_pkg::bsu_op_e'(op);
    issue_mem = m[0];
    issue_cached = c[0];
    issue_span5 = s5[0];
    issue_count_over = ov[0];
    issue_ea_clks = ea[7:0];
    issue_valid = 1'h1;
    @(posedge sys_clk);
    #1;
    issue_valid = 1'h0;
    k = 1;
    while (k < 300) begin
      // a refused request while busy must leave the op untouched
      if (poke >= 0 && k == 2) begin
        issue_op = bsu_pkg::bsu_op_e'(poke);
        issue_valid = 1'h1;
      end
      if (poke >= 0 && k == 4) issue_valid = 1'h0;
      chk(busy, 1, "busy during op");
      if (done === 1'b1) break;
      @(posedge sys_clk);
      #1;
      k++;
    end
    waits = n_wait - q0;
    chk(k, t + (m ? ea : 0) + waits, "latency");
    chk(cycle_total, t, "listed total");
    @(posedge sys_clk);
    #1;
    chk(busy, 0, "busy after done");
    chk(issue_ready, 1, "ready after done");
    chk(n_rd - r0, 2 * r, "read clocks");
    chk(n_pf - p0, c ? 0 : 2, "prefetch clocks");
    chk(n_wr - w0, 2 * w, "write clocks");
  endtask

  task automatic t_unary();
    for (int i = 0; i < 4; i++) begin
      run_op(i, 0, 1, 0, 0, 0, 2, 0, 0);
      run_op(i, 0, 0, 0, 0, 0, 2, 0, 0);
      run_op(i, 1, 1, 0, 0, 0, 3, 0, 1);
      run_op(i, 1, 0, 0, 0, 0, 4, 0, 1);
    end
    $display("test unary done");
  endtask

  task automatic t_misc();
    run_op(4, 0, 1, 0, 0, 0, 4, 0, 0);
    run_op(5, 0, 1, 0, 0, 0, 6, 0, 0);
    run_op(6, 0, 1, 0, 0, 0, 4, 0, 0);
    run_op(7, 1, 1, 0, 0, 0, 12, 1, 1);
    run_op(7, 1, 0, 0, 0, 0, 12, 1, 1);
    $display("test misc done");
  endtask

  // count flag must matter only for register-count shifts
  task automatic t_shift();
    run_op(9, 0, 1, 0, 1, 0, 4, 0, 0);
    run_op(10, 0, 1, 0, 0, 0, 6, 0, 0);
    run_op(10, 0, 0, 0, 1, 0, 8, 0, 0);
    run_op(13, 0, 1, 0, 1, 0, 4, 0, 0);
    run_op(14, 0, 1, 0, 0, 0, 6, 0, 0);
    run_op(14, 0, 1, 0, 1, 0, 10, 0, 0);
    run_op(11, 0, 1, 0, 0, 0, 6, 0, 0);
    run_op(12, 0, 1, 0, 1, 0, 8, 0, 0);
    run_op(16, 0, 1, 0, 1, 0, 8, 0, 0);
    run_op(17, 0, 1, 0, 0, 0, 12, 0, 0);
    run_op(9, 1, 1, 0, 0, 0, 4, 0, 1);
    run_op(11, 1, 0, 0, 0, 0, 6, 0, 1);
    run_op(10, 0, 1, 0, 1, 0, 8, 0, 0);
    run_op(13, 1, 1, 0, 0, 0, 4, 0, 1);
    run_op(15, 0, 1, 0, 0, 0, 6, 0, 0);
    run_op(15, 1, 1, 0, 0, 0, 6, 0, 1);
    run_op(17, 1, 0, 0, 0, 0, 4, 0, 0);
    $display("test shift done");
  endtask

  task automatic t_bit();
    run_op(18, 0, 1, 0, 0, 0, 4, 0, 0);
    run_op(18, 1, 0, 0, 0, 0, 4, 0, 0);
    for (int i = 19; i < 22; i++) begin
      run_op(i, 0, 1, 0, 0, 0, 6, 0, 0);
      run_op(i, 1, 1, 0, 0, 0, 6, 0, 1);
    end
    $display("test bit done");
  endtask

  // field ops 22..29: register, under five bytes, five bytes
  task automatic t_field();
    int rg[8] = '{8, 14, 14, 14, 10, 10, 12, 20};
    int m4[8] = '{10, 14, 14, 14, 12, 12, 12, 22};
    int m5[8] = '{14, 22, 22, 22, 18, 18, 18, 28};
    int wr[8] = '{0, 1, 1, 1, 0, 0, 1, 0};
    for (int i = 0; i < 8; i++) begin
      run_op(22 + i, 0, 1, 0, 0, 0, rg[i], 0, 0);
      run_op(22 + i, 1, 1, 0, 0, 0, m4[i], 1, wr[i]);
      run_op(22 + i, 1, 0, 1, 0, 0, m5[i], 2, 2 * wr[i]);
    end
    $display("test field done");
  endtask

  // address time runs apart and only for memory forms
  task automatic t_ea();
    run_op(0, 1, 1, 0, 0, 5, 3, 0, 1);
    run_op(0, 0, 1, 0, 0, 7, 2, 0, 0);
    run_op(29, 1, 1, 0, 0, 3, 22, 1, 0);
    run_op(29, 1, 1, 1, 0, 9, 28, 2, 0);
    $display("test address done");
  endtask

  task automatic t_wait();
    slow = 1'h1;
    run_op(0, 1, 0, 0, 0, 0, 4, 0, 1);
    chk(waits > 0, 1, "no wait inserted");
    run_op(23, 1, 1, 1, 0, 2, 22, 2, 2);
    slow = 1'h0;
    $display("test wait done");
  endtask

  task automatic t_refuse();
    poke = 0;
    run_op(5, 0, 1, 0, 0, 0, 6, 0, 0);
    poke = 23;
    run_op(17, 0, 0, 0, 0, 0, 12, 0, 0);
    poke = -1;
    $display("test refuse done");
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // about 78 ops of at most 40 clocks each fit well inside this span
  initial begin
    #400000;
    fails++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'h1;
    chk(busy, 0, "busy at reset");
    chk(issue_ready, 1, "ready at reset");
    chk(cycle_total, 0, "total at reset");
    t_unary();
    t_misc();
    t_shift();
    t_bit();
    t_field();
    t_ea();
    t_wait();
    t_refuse();
    print_verdict();
  end
endmodule
